// ==== rtl/scp_defines.svh ====
// Behaviour
// [RL1] Chip select low starts a transaction.
// [RL2] First command bit: high read, low write.
// [RL3] Fifteen address bits follow, MSB first.
// [RL4] Address steps by one per further word.
// [RL5] Write commands never drive the data line.
// [RL6] Read commands shift register data out.
// [RL7] Chip select high aborts and releases lines.
// [RL8] Pattern RAM maps to 0x6000 through 0x6fff.
// [RL9] Dual mode: shared pin is second input.
// [RL10] Dual mode loads RAM in half the clocks.
// [RL11] Shadow copy written, active copy controls.
// [RL12] Arm bit in transfer register arms copy.
// [RL13] Armed copy happens when generator is off.
// [RL14] RAM writes bypass shadow and arm bit.
// [RL15] Four-wire reads use the shared output pin; with dual mode set the device drives them on sdio.
// [RL16] Reset pin restores configuration defaults.
// [RL17] Sample on rising, launch on falling edge.
// [RL18] Sixteen-bit words, RAM entry in top twelve.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
`define SCP_WORD_LAST   4'hf
`define SCP_DUAL_LAST   4'h7
`define SCP_RAM_BASE    15'h6000
`define SCP_RAM_TOP     15'h6fff
`define SCP_RAM_DEPTH   4096
`define SCP_CFG_NUM     8
`define SCP_CFG_TOP     15'h0007
`define SCP_XFER_ADDR   15'h001d
`define SCP_ARM_BIT     0
`define SCP_CFG_RST     16'h0000
`define SCP_CLK_NS      25
`define SCP_SCLK_HALF_NS 200
`define SCP_SCLK_HALF   ((`SCP_SCLK_HALF_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_FIFO_DEPTH  32
`define SCP_FIFO_WIDTH  16
`endif

// ==== rtl/scp_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_dev (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Serial link
  scp_if.dev                    lnk,
  // Mode straps
  input  wire logic             four_wire,
  input  wire logic             dual_mode,
  // Pattern generator side
  input  wire logic             pattern_off,
  input  wire logic [11:0]      pat_addr,
  output logic [11:0]           pat_data,
  output scp_pkg::scp_cfg_t     active_cfg,
  output logic                  update_armed
);
  typedef struct packed {
    scp_pkg::scp_pins_s   s1;
    scp_pkg::scp_pins_s   s2;
    logic                 sclk_q;
    scp_pkg::scp_dphase_e ph;
    logic [3:0]           cnt;
    logic [15:0]          sh;
    logic                 rd;
    logic [14:0]          addr;
    logic [15:0]          tx;
    logic                 sdio_o;
    logic                 sdio_oe;
    logic                 shr_o;
    logic                 shr_oe;
    scp_pkg::scp_cfg_t    shadow;
    scp_pkg::scp_cfg_t    active;
    logic                 armed;
    logic [11:0]          pat;
  } scp_dev_s;

  scp_dev_s    q;
  scp_dev_s    next_q;
  logic [11:0] ram [`SCP_RAM_DEPTH];
  logic        ram_we;
  logic [11:0] ram_wa;
  logic [11:0] ram_wd;

  // Read image of one address; holes read as zero.
  function automatic logic [15:0] rd_image(input logic [14:0] a,
                                           input scp_pkg::scp_cfg_t sh,
                                           input logic arm);
    logic [15:0] v;
    v = 16'h0000;
    // [RL8] RAM address window.
    if (a >= `SCP_RAM_BASE && a <= `SCP_RAM_TOP) begin
      // [RL18] Entry in top bits.
      v = {ram[12'(a - `SCP_RAM_BASE)], 4'h0};
    end else if (a <= `SCP_CFG_TOP) begin
      v = sh[3'(a)];
    end else if (a == `SCP_XFER_ADDR) begin
      v[`SCP_ARM_BIT] = arm;
    end
    return v;
  endfunction

  logic        rise;
  logic        fall;
  logic [3:0]  last;
  logic [15:0] word;
  logic [14:0] nxt_addr;

  always_comb begin
    next_q = q;
    ram_we = 1'b0;
    ram_wa = 12'h000;
    ram_wd = 12'h000;
    next_q.s1 = '{sclk: lnk.sclk, cs_n: lnk.cs_n, sdio: lnk.sdio,
                  shr: lnk.shr, rst_n: lnk.rst_n};
    next_q.s2 = q.s1;
    next_q.sclk_q = q.s2.sclk;
    next_q.pat = ram[pat_addr];
    rise = q.s2.sclk & ~q.sclk_q;
    fall = ~q.s2.sclk & q.sclk_q;
    nxt_addr = 15'(q.addr + 15'h0001);
    // Read data always uses one line; in dual mode command words and write data are split.
    last = (dual_mode && !(q.ph == scp_pkg::PH_DATA && q.rd)) ?
           `SCP_DUAL_LAST : `SCP_WORD_LAST;
    // [RL9] Second input carries low byte.
    if (dual_mode) begin
      word = {q.sh[14:8], q.s2.sdio, q.sh[6:0], q.s2.shr};
    end else begin
      word = {q.sh[14:0], q.s2.sdio};
    end
    // [RL13] Copy when generator off.
    if (q.armed && pattern_off) begin
      next_q.active = q.shadow;
      next_q.armed = 1'b0;
    end
    if (q.s2.cs_n) begin
      // [RL7] Abort and release.
      next_q.ph = scp_pkg::PH_IDLE;
      next_q.cnt = 4'h0;
      next_q.sdio_oe = 1'b0;
      next_q.shr_oe = 1'b0;
    end else if (q.ph == scp_pkg::PH_IDLE) begin
      // [RL1] Select opens command.
      next_q.ph = scp_pkg::PH_CMD;
      next_q.cnt = 4'h0;
    end else if (rise) begin
      // [RL17] Sample on rising edge.
      next_q.sh = word;
      next_q.cnt = 4'(q.cnt + 4'h1);
      if (q.cnt == last) begin
        next_q.cnt = 4'h0;
        if (q.ph == scp_pkg::PH_CMD) begin
          // [RL2] Direction flag decode.
          next_q.rd = word[15];
          // [RL3] Start address capture.
          next_q.addr = word[14:0];
          next_q.ph = scp_pkg::PH_DATA;
          next_q.tx = rd_image(word[14:0], q.shadow, q.armed);
        end else begin
          // [RL4] Step to next address.
          next_q.addr = nxt_addr;
          next_q.tx = rd_image(nxt_addr, q.shadow, q.armed);
          if (!q.rd) begin
            if (q.addr >= `SCP_RAM_BASE && q.addr <= `SCP_RAM_TOP) begin
              // [RL14] RAM written directly.
              ram_we = 1'b1;
              ram_wa = 12'(q.addr - `SCP_RAM_BASE);
              ram_wd = word[15:4];
            end else if (q.addr <= `SCP_CFG_TOP) begin
              // [RL11] Writes land in shadow.
              next_q.shadow[3'(q.addr)] = word;
            end else if (q.addr == `SCP_XFER_ADDR &&
                         word[`SCP_ARM_BIT]) begin
              // [RL12] Arm the transfer.
              next_q.armed = 1'b1;
            end
          end
        end
      end
    end else if (fall && q.ph == scp_pkg::PH_DATA && q.rd) begin
      // [RL6] Shift read data out.
      next_q.tx = {q.tx[14:0], 1'b0};
      // [RL15] Four-wire uses shared pin, except in dual mode.
      if (four_wire && !dual_mode) begin
        next_q.shr_o = q.tx[15];
        next_q.shr_oe = 1'b1;
      end else begin
        next_q.sdio_o = q.tx[15];
        next_q.sdio_oe = 1'b1;
      end
    end
    // [RL5] Write data never driven.
    if (!q.rd || q.ph != scp_pkg::PH_DATA) begin
      next_q.sdio_oe = 1'b0;
      next_q.shr_oe = 1'b0;
    end
    // [RL16] Reset pin restores defaults.
    if (!q.s2.rst_n) begin
      next_q.shadow = {`SCP_CFG_NUM{`SCP_CFG_RST}};
      next_q.active = {`SCP_CFG_NUM{`SCP_CFG_RST}};
      next_q.armed = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.s1.cs_n <= 1'b1;
      q.s2.cs_n <= 1'b1;
      q.s1.rst_n <= 1'b1;
      q.s2.rst_n <= 1'b1;
      q.shadow <= {`SCP_CFG_NUM{`SCP_CFG_RST}};
      q.active <= {`SCP_CFG_NUM{`SCP_CFG_RST}};
    end else begin
      q <= next_q;
    end
  end

  // The RAM has no reset; its contents are unknown until loaded.
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign lnk.sdio_s    = q.sdio_o;
  assign lnk.sdio_s_oe = q.sdio_oe;
  assign lnk.shr_s     = q.shr_o;
  assign lnk.shr_s_oe  = q.shr_oe;
  assign pat_data      = q.pat;
  assign active_cfg    = q.active;
  assign update_armed  = q.armed;
endmodule
`default_nettype wire

// ==== rtl/scp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } scp_fifo_s;
  scp_fifo_s q;
  scp_fifo_s next_q;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;
  assign in_ready  = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = (q.wp == AW'(D-1)) ? '0 : AW'(q.wp + 1'b1);
    end
    if (pop) begin
      next_q.rp = (q.rp == AW'(D-1)) ? '0 : AW'(q.rp + 1'b1);
    end
    next_q.cnt = (AW+1)'(q.cnt + push - pop);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/scp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Serial link
  scp_if.host              lnk,
  // Request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_rd,
  input  wire logic        req_dual,
  input  wire logic [14:0] req_addr,
  input  wire logic [12:0] req_len,
  input  wire logic        four_wire,
  input  wire logic        dev_reset,
  // Write data
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [15:0] wr_data,
  // Read data
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  typedef struct packed {
    logic [1:0]           s1;
    logic [1:0]           s2;
    scp_pkg::scp_hstate_e st;
    logic [3:0]           div;
    logic                 sclk;
    logic                 cs_n;
    logic                 hdr;
    logic [15:0]          sh;
    logic [15:0]          rx;
    logic [3:0]           cnt;
    logic [12:0]          left;
    logic                 rd;
    logic                 dual;
    logic                 sdio_oe;
    logic                 shr_oe;
    logic                 rst_n;
    logic                 ready;
    logic                 rv;
    logic [15:0]          rdat;
  } scp_host_s;

  scp_host_s   q;
  scp_host_s   next_q;
  logic        f_valid;
  logic        f_pop;
  logic [15:0] f_data;
  logic [3:0]  last;
  logic        tick;

  // Deep enough to cover a burst while the user refills.
  scp_fifo #(.W(`SCP_FIFO_WIDTH), .D(`SCP_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign f_pop = q.st == scp_pkg::HS_FETCH;

  always_comb begin
    next_q = q;
    next_q.s1 = {lnk.sdio, lnk.shr};
    next_q.s2 = q.s1;
    next_q.rst_n = ~dev_reset;
    next_q.rv = 1'b0;
    last = q.dual ? `SCP_DUAL_LAST : `SCP_WORD_LAST;
    tick = q.div == 4'(`SCP_SCLK_HALF - 1);
    next_q.div = tick ? 4'h0 : 4'(q.div + 4'h1);
    case (q.st)
      scp_pkg::HS_IDLE: begin
        next_q.div = 4'h0;
        if (req_valid) begin
          // [RL1] Lower select to start.
          next_q.cs_n = 1'b0;
          // [RL2] Flag then address.
          next_q.sh = {req_rd, req_addr};
          next_q.rd = req_rd;
          next_q.dual = req_dual & ~req_rd;
          next_q.left = req_len;
          next_q.cnt = 4'h0;
          next_q.hdr = 1'b1;
          next_q.sdio_oe = 1'b1;
          next_q.shr_oe = req_dual & ~req_rd;
          next_q.ready = 1'b0;
          next_q.st = scp_pkg::HS_SHIFT;
        end
      end
      scp_pkg::HS_FETCH: begin
        next_q.div = 4'h0;
        next_q.st = f_valid ? scp_pkg::HS_SHIFT : scp_pkg::HS_FETCH;
        next_q.sh = f_data;
      end
      scp_pkg::HS_SHIFT: begin
        if (tick) begin
          next_q.sclk = ~q.sclk;
          if (!q.sclk) begin
            // [RL17] Master samples on rise.
            next_q.rx = {q.rx[14:0], four_wire ? q.s2[0] : q.s2[1]};
          end else begin
            // [RL10] Two bits per clock.
            next_q.sh = q.dual ? {q.sh[14:8], 1'b0, q.sh[6:0], 1'b0}
                               : {q.sh[14:0], 1'b0};
            next_q.cnt = 4'(q.cnt + 4'h1);
            if (q.cnt == last) begin
              next_q.cnt = 4'h0;
              next_q.hdr = 1'b0;
              if (!q.hdr && q.rd) begin
                next_q.rv = 1'b1;
                next_q.rdat = q.rx;
              end
              // [RL5] Release line for reads.
              if (q.rd) begin
                next_q.sdio_oe = 1'b0;
              end
              // The command word is not counted against the word budget.
              if (!q.hdr && q.left == 13'h0000) begin
                next_q.st = scp_pkg::HS_DONE;
              end else begin
                // [RL4] Further words continue.
                if (!q.hdr) begin
                  next_q.left = 13'(q.left - 13'h0001);
                end
                next_q.st = q.rd ? scp_pkg::HS_SHIFT : scp_pkg::HS_FETCH;
              end
            end
          end
        end
      end
      scp_pkg::HS_DONE: begin
        // A deselected half period lets the device release the line first.
        if (tick && q.cs_n) begin
          next_q.ready = 1'b1;
          next_q.st = scp_pkg::HS_IDLE;
        end else if (tick) begin
          // [RL7] Raise select to end.
          next_q.cs_n = 1'b1;
          next_q.sdio_oe = 1'b0;
          next_q.shr_oe = 1'b0;
        end
      end
      default: begin
        next_q.st = scp_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.rst_n <= 1'b1;
      q.ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign lnk.cs_n      = q.cs_n;
  assign lnk.sclk      = q.sclk;
  assign lnk.rst_n     = q.rst_n;
  assign lnk.sdio_m    = q.sh[15];
  assign lnk.sdio_m_oe = q.sdio_oe;
  assign lnk.shr_m     = q.sh[7];
  assign lnk.shr_m_oe  = q.shr_oe;
  assign req_ready     = q.ready;
  assign rd_valid      = q.rv;
  assign rd_data       = q.rdat;
endmodule
`default_nettype wire

// ==== rtl/scp_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
  logic cs_n;
  logic sclk;
  logic rst_n;
  logic sdio_m;
  logic sdio_m_oe;
  logic sdio_s;
  logic sdio_s_oe;
  logic shr_m;
  logic shr_m_oe;
  logic shr_s;
  logic shr_s_oe;
  logic sdio;
  logic shr;
  // Undriven lines float high, as with a weak pull-up.
  assign sdio = sdio_m_oe ? sdio_m : (sdio_s_oe ? sdio_s : 1'b1);
  assign shr  = shr_m_oe ? shr_m : (shr_s_oe ? shr_s : 1'b1);
  modport dev (input cs_n, sclk, rst_n, sdio, shr,
               output sdio_s, sdio_s_oe, shr_s, shr_s_oe);
  modport host (output cs_n, sclk, rst_n, sdio_m, sdio_m_oe, shr_m, shr_m_oe,
                input sdio, shr);
endinterface
`default_nettype wire

// ==== rtl/scp_pkg.sv ====
`include "scp_defines.svh"
package scp_pkg;
  typedef logic [`SCP_CFG_NUM-1:0][15:0] scp_cfg_t;
  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA} scp_dphase_e;
  typedef enum logic [1:0] {HS_IDLE, HS_FETCH, HS_SHIFT, HS_DONE} scp_hstate_e;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
    logic shr;
    logic rst_n;
  } scp_pins_s;
endpackage

// ==== tb/scp_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_asserts (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Link lines
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic sdio,
  input  wire logic sdio_m_oe,
  input  wire logic sdio_s_oe,
  input  wire logic shr_m_oe,
  input  wire logic shr_s_oe
);
  logic        sclk_q;
  logic        rd;
  logic [11:0] cnt;
  wire         rise = sclk & ~sclk_q;
  wire         fall = ~sclk & sclk_q;

  // Rising edges of the link clock are counted per frame.
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (srst || cs_n)
      cnt <= '0;
    else if (rise)
      cnt <= cnt + 12'h001;
    if (rise && cnt == 12'h000)
      rd <= sdio;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sclk_idle_a: assert property (
    cs_n |-> !sclk) else $error("link clock high while deselected");
  oe_release_a: assert property (
    $rose(cs_n) |-> ##[0:3] !(sdio_s_oe || shr_s_oe || sdio_m_oe || shr_m_oe))
    else $error("lines still driven after deselect");
  no_clash_a: assert property (
    !(sdio_m_oe && sdio_s_oe) && !(shr_m_oe && shr_s_oe))
    else $error("two drivers on one line");
  wr_quiet_a: assert property (
    (!cs_n && cnt != 12'h000 && !rd) |-> !sdio_s_oe && !shr_s_oe)
    else $error("device drives during a write");
  rd_drive_a: assert property (
    (!cs_n && rd && cnt == 12'h010 && fall) |-> ##[1:6] (sdio_s_oe || shr_s_oe))
    else $error("device silent after read command");
  rd_turn_a: assert property (
    (!cs_n && rd && cnt == 12'h011) |-> !shr_m_oe)
    else $error("host drives shared pin during read");
  half_period_a: assert property (
    $rose(sclk) |=> sclk [*7] ##1 !sclk) else $error("link clock high phase");
  whole_word_a: assert property (
    $rose(cs_n) |-> cnt[2:0] == 3'h0 && cnt >= 12'h010)
    else $error("frame ended on a part word");
  data_stable_a: assert property (
    (sclk && $past(sclk)) |-> $stable(sdio))
    else $error("data moved while link clock high");
endmodule
`default_nettype wire

// ==== tb/serial_config_and_pattern_ram_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_config_and_pattern_ram_port_bench;
  logic              clk, srst, dev_srst, pattern_off, dual_mode, four_wire;
  logic              req_valid, req_ready, req_rd, req_dual, dev_reset;
  logic              wr_valid, wr_ready, rd_valid, update_armed;
  logic [14:0]       req_addr;
  logic [12:0]       req_len;
  logic [15:0]       wr_data, rd_data;
  logic [11:0]       pat_addr, pat_data;
  scp_pkg::scp_cfg_t active_cfg;
  logic [15:0]       rdq[$];
  int                num_errors, samples_checked, ts, td, c;

  scp_if lnk ();
  scp_host u_scp_host (.clk(clk), .srst(srst), .lnk(lnk.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_rd(req_rd),
    .req_dual(req_dual), .req_addr(req_addr), .req_len(req_len),
    .four_wire(four_wire), .dev_reset(dev_reset), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data));
  scp_dev u_scp_dev (.clk(clk), .srst(dev_srst), .lnk(lnk.dev),
    .four_wire(four_wire), .dual_mode(dual_mode), .pattern_off(pattern_off),
    .pat_addr(pat_addr), .pat_data(pat_data), .active_cfg(active_cfg),
    .update_armed(update_armed));
  scp_asserts u_scp_asserts (.clk(clk), .srst(srst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .sdio(lnk.sdio), .sdio_m_oe(lnk.sdio_m_oe),
    .sdio_s_oe(lnk.sdio_s_oe), .shr_m_oe(lnk.shr_m_oe),
    .shr_s_oe(lnk.shr_s_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Read words are taken mid-cycle, where the registered pulse is settled.
  always @(negedge clk) begin
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);
  end

  function automatic logic [15:0] v(input int i);
    return 16'h3c50 ^ 16'(i * 16'h0193);
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic push(input logic [15:0] w);
    wr_data = w;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) step(1);
    step(1);
  endtask

  // A nonzero kill resets the host that many cycles in, cutting the frame.
  task automatic xfer(input logic rd, dual, input logic [14:0] a,
                      input logic [12:0] n, input int kill, output int cyc);
    req_rd = rd;
    req_dual = dual;
    req_addr = a;
    req_len = n;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) step(1);
    step(1);
    req_valid = 1'b0;
    cyc = 0;
    while (req_ready !== 1'b1 && cyc < 20000) begin
      step(1);
      cyc++;
      if (cyc == kill)
        srst = 1'b1;
    end
    if (kill != 0) begin
      step(1);
      srst = 1'b0;
    end
    check("request done", 16'(req_ready), 16'h0001);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] exp);
    check(nm, (rdq.size() > 0) ? rdq.pop_front() : 16'hxxxx, exp);
  endtask

  task automatic pat_chk(input logic [11:0] a, input logic [15:0] w);
    pat_addr = a;
    step(2);
    check("pat_data", 16'(pat_data), 16'(w[15:4]));
  endtask

  initial begin
    #1000000;
    num_errors++;
    test_done();
  end

  initial begin
    {srst, dev_srst} = 2'h3;
    {pattern_off, dual_mode, four_wire, dev_reset} = 4'h0;
    {req_valid, req_rd, req_dual, wr_valid} = 4'h0;
    req_addr = 15'h0000;
    req_len = 13'h0000;
    wr_data = 16'h0000;
    pat_addr = 12'h000;
    step(16);
    {srst, dev_srst} = 2'h0;
    step(1);
    for (int i = 0; i < 8; i++) push(v(i));
    wr_valid = 1'b0;
    xfer(1'b0, 1'b0, 15'h0000, 13'h0007, 0, c);
    xfer(1'b1, 1'b0, 15'h0000, 13'h0008, 0, c);
    for (int i = 0; i < 8; i++) rd_chk("shadow", v(i));
    rd_chk("unmapped", 16'h0000);
    check("active", active_cfg[0], 16'h0000);
    $display("test shadow done");
    push(16'h0001);
    wr_valid = 1'b0;
    xfer(1'b0, 1'b0, 15'h001d, 13'h0000, 0, c);
    check("armed", 16'(update_armed), 16'h0001);
    check("held", active_cfg[1], 16'h0000);
    xfer(1'b1, 1'b0, 15'h001d, 13'h0000, 0, c);
    rd_chk("arm readback", 16'h0001);
    pattern_off = 1'b1;
    step(4);
    for (int i = 0; i < 8; i++) check("copied", active_cfg[i], v(i));
    check("disarmed", 16'(update_armed), 16'h0000);
    pattern_off = 1'b0;
    $display("test arm done");
    for (int i = 0; i < 4; i++) push(v(i + 8));
    wr_valid = 1'b0;
    xfer(1'b0, 1'b0, 15'h6ffc, 13'h0003, 0, ts);
    for (int i = 0; i < 4; i++) pat_chk(12'hffc + 12'(i), v(i + 8));
    check("no arm", 16'(update_armed), 16'h0000);
    $display("test ram done");
    dual_mode = 1'b1;
    for (int i = 0; i < 4; i++) push(v(i + 12));
    wr_valid = 1'b0;
    xfer(1'b0, 1'b1, 15'h6000, 13'h0003, 0, td);
    check("dual time", 16'(ts - td), 16'h0280);
    for (int i = 0; i < 32; i++) push(v(i + 16));
    wr_valid = 1'b0;
    check("fifo full", 16'(wr_ready), 16'h0000);
    xfer(1'b0, 1'b1, 15'h6004, 13'h001f, 0, c);
    check("fifo empty", 16'(wr_ready), 16'h0001);
    for (int i = 0; i < 36; i++) pat_chk(12'(i), v(i + 12));
    dual_mode = 1'b0;
    $display("test dual done");
    four_wire = 1'b1;
    xfer(1'b1, 1'b0, 15'h0007, 13'h0001, 0, c);
    rd_chk("four wire", v(7));
    rd_chk("four wire tail", 16'h0000);
    four_wire = 1'b0;
    $display("test four wire done");
    push(16'hffff);
    wr_valid = 1'b0;
    xfer(1'b0, 1'b0, 15'h0000, 13'h0000, 360, c);
    step(4);
    xfer(1'b1, 1'b0, 15'h0000, 13'h0000, 0, c);
    rd_chk("abort", v(0));
    $display("test abort done");
    dev_reset = 1'b1;
    step(6);
    dev_reset = 1'b0;
    step(6);
    xfer(1'b1, 1'b0, 15'h0000, 13'h0000, 0, c);
    rd_chk("reset reg", 16'h0000);
    check("reset active", active_cfg[0], 16'h0000);
    $display("test link reset done");
    test_done();
  end
endmodule
`default_nettype wire
